// ---- bench/adc_serial_readout_chain_test.sv ----
// Host end reads the converter end in all four modes, with a reset mid-run
`timescale 1ns/1ns
`default_nettype none
module adc_serial_readout_chain_test;
  localparam int CONV = 16;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic use_chain = 1'b0;
  logic use_busy = 1'b0;
  logic [17:0] sample_data = 18'h0_0000;
  logic [17:0] result;
  logic done;
  logic active;
  logic converting;
  logic chain_mode;
  logic busy_enabled;
  logic sck_q = 1'b0;
  logic lvl_q = 1'b1;
  logic [18:0] wire_sh = 19'h0_0000;
  int falls = 0;
  int miscompares = 0;
  int checks_done = 0;
  asr_link_if lk ();
  asr_dev #(.CONV_CYC(CONV)) asr_dev_i (.clk(clk), .rst_b(rst_b), .link(lk.dev),
    .sample_data(sample_data), .converting(converting), .chain_mode(chain_mode),
    .busy_enabled(busy_enabled));
  asr_host #(.N_DEV(1), .SCK_HALF(8), .CONV_WAIT(CONV + 8)) asr_host_i (.clk(clk),
    .rst_b(rst_b), .link(lk.host), .start(start), .use_chain(use_chain),
    .use_busy(use_busy), .result(result), .done(done), .active(active));
  asr_assertions #(.CONV_CYC(CONV)) asr_assertions_i (.clk(clk), .rst_b(rst_b),
    .convert_strobe(lk.convert_strobe), .select_serial_in(lk.select_serial_in),
    .sck(lk.sck), .serial_result_out(lk.serial_result_out),
    .serial_result_oe(lk.serial_result_oe));
  always #2 clk = ~clk;
  // Take the line level just before each clock fall, as a host would
  always @(posedge clk) begin
    sck_q <= lk.sck;
    lvl_q <= lk.serial_result_level;
    // The clock drop during a chain-busy conversion is set-up, not a data bit
    if (sck_q && !lk.sck && !converting) begin
      wire_sh <= {wire_sh[17:0], lvl_q};
      falls <= falls + 1;
    end
  end
  task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic wait_hi(input bit for_done);
    int n;
    n = 0;
    while ((for_done ? done : converting) !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_hi
  task automatic read_one(input logic ch, input logic bz, input logic [17:0] d);
    int f0;
    f0 = falls;
    @(posedge clk);
    sample_data <= d;
    use_chain <= ch;
    use_busy <= bz;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wait_hi(1'b0);
    repeat (3) @(posedge clk);
    if (!ch) chk("oe converting", 19'h0_0000, {18'h0_0000, lk.serial_result_oe});
    chk("active", 19'h0_0001, {18'h0_0000, active});
    chk("strobe held", 19'h0_0001, {18'h0_0000, lk.convert_strobe});
    wait_hi(1'b1);
    chk("result", {1'b0, d}, {1'b0, result});
    chk("mode", {17'h0_0000, ch, bz}, {17'h0_0000, chain_mode, busy_enabled});
    chk("falls", 19'(18 + bz), 19'(falls - f0));
    chk("wire", bz ? {ch, d} : {1'b0, d}, bz ? wire_sh : {1'b0, wire_sh[17:0]});
    repeat (8) @(posedge clk);
    if (!ch) chk("oe after", 19'h0_0000, {18'h0_0000, lk.serial_result_oe});
    chk("active after", 19'h0_0000, {18'h0_0000, active});
  endtask : read_one
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      read_one(m[1], m[0], 18'h2_0001);
      read_one(m[1], m[0], 18'h1_fffe);
    end
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (40) @(posedge clk);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    chk("result reset", 19'h0_0000, {1'b0, result});
    read_one(1'b0, 1'b1, 18'h3_ffff);
    wrap_up();
  end
endmodule : adc_serial_readout_chain_test
`default_nettype wire

// ---- bench/asr_assertions.sv ----
// Link checks between the converter end and the host end
`timescale 1ns/1ns
`default_nettype none
module asr_assertions #(
  parameter int CONV_CYC = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic convert_strobe,
  input wire logic select_serial_in,
  input wire logic sck,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  // Conversion end plus sync latency, still before the first data clock fall
  localparam int END_CYC = CONV_CYC + 4;
  logic strobe_q;
  logic chain_q;
  logic busy_q;
  logic [7:0] cnt_q;
  wire strobe_rise = convert_strobe && !strobe_q;
  wire cnt_sat = cnt_q == 8'hff;
  wire at_end = cnt_q == 8'(END_CYC);
  always_ff @(posedge clk) begin
    strobe_q <= rst_b && convert_strobe;
    if (!rst_b) begin
      cnt_q <= 8'hff;
    end else if (strobe_rise) begin
      cnt_q <= 8'h00;
      chain_q <= !select_serial_in;
      busy_q <= sck;
    end else if (!cnt_sat) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_both_low;
    (!convert_strobe && !select_serial_in) [*4];
  endsequence
  sequence s_sel_end;
    !chain_q && convert_strobe && at_end;
  endsequence
  a_low_drive_idle: assert property (
    s_both_low |-> serial_result_oe && !serial_result_out) else $error("idle line not low");
  a_start_release: assert property (
    $rose(convert_strobe) && select_serial_in |-> ##[2:8] !serial_result_oe)
    else $error("no release at start");
  a_hiz_converting: assert property (
    !chain_q && convert_strobe && cnt_q inside {[8:CONV_CYC]} |-> !serial_result_oe)
    else $error("driven while converting");
  a_sel_release: assert property (
    !chain_q && convert_strobe && $rose(select_serial_in) |-> ##[1:8] !serial_result_oe)
    else $error("no release on select rise");
  a_bit_stable: assert property (
    $rose(sck) && serial_result_oe && $past(serial_result_oe) |-> $stable(serial_result_out))
    else $error("bit moved at rising clock");
  a_sel_busy_start: assert property (
    s_sel_end ##0 !select_serial_in |-> serial_result_oe && !serial_result_out)
    else $error("no busy start bit");
  a_chain_msb_drive: assert property (
    chain_q && !busy_q && at_end |-> serial_result_oe) else $error("chain result not driven");
  a_chain_busy_high: assert property (
    chain_q && busy_q && at_end |-> serial_result_oe && serial_result_out)
    else $error("chain busy not high");
endmodule : asr_assertions
`default_nettype wire

// ---- hw/asr_dev.sv ----
// Converter end: conversion timing, mode select and serial result output
//
// Function
// - Select-mode strobe rise starts conversion, output released
// - Host holds strobe high through conversion, readback
// - Select and strobe both low: drive output low
// - No-busy: select high before min, hold max
// - Conversion end enters acquisition, then standby
// - No-busy: select low shows MSB, falls shift
// - Data bit valid across both clock edges
// - No-busy: release at 18th fall or select rise
// - Busy: host holds select low through conversion
// - Busy: output driven at end, then MSB first
// - Busy: release at 19th fall or select rise
// - Strobe rise, clock low: chain, no busy
// - Chain no-busy: MSB at end, falls shift
// - Chain: select input shifted in on falls
// - Chain no-busy: host gives 18 clocks per converter
// - Strobe rise, clock high: chain, busy enabled
// - Chain busy: drive output high at end
// - Chain busy: host gives 18N plus one clocks
// - Strobe rise picks mode from select level
`timescale 1ns/1ns
`default_nettype none
module asr_dev #(
  parameter int CONV_CYC = asr_pkg::CONV_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  asr_link_if.dev link,
  input wire logic [asr_pkg::RES_W-1:0] sample_data,
  output logic converting,
  output logic chain_mode,
  output logic busy_enabled
);
  typedef enum logic [1:0] {D_IDLE, D_CONV, D_READ} asr_dev_st_t;
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);
  localparam logic [4:0] LIM_NOBUSY = 5'(asr_pkg::BITS_NOBUSY);
  localparam logic [4:0] LIM_BUSY = 5'(asr_pkg::BITS_BUSY);

  // Two-stage synchronisers; stage one is read only by stage two
  logic [1:0] cnv_m_q, sdi_m_q, sck_m_q;
  logic cnv_s, sdi_s, sck_s, cnv_p_q, sdi_p_q, sck_p_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnv_m_q <= 2'h0;
      // Select idles high; resetting to that level avoids a false edge
      // and a spurious low drive in the cycles right after reset
      sdi_m_q <= 2'h3;
      sck_m_q <= 2'h0;
      cnv_p_q <= 1'b0;
      sdi_p_q <= 1'b1;
      sck_p_q <= 1'b0;
    end else begin
      cnv_m_q <= {cnv_m_q[0], link.convert_strobe};
      sdi_m_q <= {sdi_m_q[0], link.select_serial_in};
      sck_m_q <= {sck_m_q[0], link.sck};
      cnv_p_q <= cnv_s;
      sdi_p_q <= sdi_s;
      sck_p_q <= sck_s;
    end
  end
  assign cnv_s = cnv_m_q[1];
  assign sdi_s = sdi_m_q[1];
  assign sck_s = sck_m_q[1];

  wire cnv_rise = cnv_s & ~cnv_p_q;
  wire sdi_rise = sdi_s & ~sdi_p_q;
  wire sdi_fall = ~sdi_s & sdi_p_q;
  wire sck_fall = ~sck_s & sck_p_q;
  wire force_low = ~cnv_s & ~sdi_s;

  asr_dev_st_t st_q, st_d;
  logic chain_q, chain_d, busy_q, busy_d, rd_q, rd_d, oe_q, oe_d, out_q, out_d;
  logic [CW-1:0] cyc_q, cyc_d;
  logic [4:0] cnt_q, cnt_d;
  logic [asr_pkg::RES_W-1:0] data_q, data_d;
  logic [asr_pkg::SH_W-1:0] sh_q, sh_d;

  wire [4:0] lim = busy_q ? LIM_BUSY : LIM_NOBUSY;
  wire [4:0] cnt_inc = cnt_q + 5'h1;
  wire conv_end = (st_q == D_CONV) && (cyc_q == CONV_LAST);
  wire [asr_pkg::SH_W-1:0] sh_shift = {sh_q[asr_pkg::SH_W-2:0], sdi_s};

  always_comb begin
    st_d = st_q;
    chain_d = chain_q;
    busy_d = busy_q;
    rd_d = rd_q;
    oe_d = oe_q;
    cyc_d = cyc_q;
    cnt_d = cnt_q;
    data_d = data_q;
    sh_d = sh_q;
    if (cnv_rise) begin
      // A new strobe edge always restarts, even mid-readout
      st_d = D_CONV;
      chain_d = ~sdi_s;
      busy_d = ~sdi_s & sck_s;
      oe_d = ~sdi_s;
      rd_d = 1'b0;
      cyc_d = '0;
      cnt_d = '0;
      data_d = sample_data;
      sh_d = '0;
    end else begin
      case (st_q)
        D_CONV: begin
          cyc_d = cyc_q + CW'(1);
          if (conv_end) begin
            st_d = D_READ;
            cnt_d = '0;
            if (chain_q) begin
              oe_d = 1'b1;
              // Busy start bit ahead of data when enabled
              sh_d = busy_q ? {1'b1, data_q} : {data_q, 1'b0};
            end else begin
              // Select low at end of conversion asks for the busy bit
              busy_d = ~sdi_s;
              rd_d = ~sdi_s;
              oe_d = ~sdi_s;
              sh_d = ~sdi_s ? {1'b0, data_q} : {data_q, 1'b0};
            end
          end
        end
        D_READ: begin
          if (chain_q) begin
            if (sck_fall) begin
              sh_d = sh_shift;
            end
          end else if (rd_q) begin
            if (sck_fall) begin
              sh_d = sh_shift;
              cnt_d = cnt_inc;
            end
            if (sdi_rise || (sck_fall && cnt_inc == lim)) begin
              rd_d = 1'b0;
              oe_d = 1'b0;
              st_d = D_IDLE;
            end
          end else if (sdi_fall) begin
            rd_d = 1'b1;
            oe_d = 1'b1;
          end
        end
        D_IDLE: begin
          oe_d = 1'b0;
        end
        default: begin
          st_d = D_IDLE;
        end
      endcase
    end
    // Select and strobe both low force the line driven; entering idle releases it
    if (force_low) begin
      oe_d = 1'b1;
    end else if (st_d == D_IDLE) begin
      oe_d = 1'b0;
    end
  end

  // Bit changes only after a fall, so it is steady across the rise and next fall
  assign out_d = force_low ? 1'b0 : sh_d[asr_pkg::SH_W-1];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= D_IDLE;
      chain_q <= 1'b0;
      busy_q <= 1'b0;
      rd_q <= 1'b0;
      oe_q <= 1'b0;
      out_q <= 1'b0;
      cyc_q <= '0;
      cnt_q <= 5'h0;
      data_q <= '0;
      sh_q <= '0;
    end else begin
      st_q <= st_d;
      chain_q <= chain_d;
      busy_q <= busy_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      out_q <= out_d;
      cyc_q <= cyc_d;
      cnt_q <= cnt_d;
      data_q <= data_d;
      sh_q <= sh_d;
    end
  end

  // Registered so the status output comes straight from a flip-flop
  logic conv_o_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conv_o_q <= 1'b0;
    end else begin
      conv_o_q <= (st_d == D_CONV);
    end
  end

  assign link.serial_result_out = out_q;
  assign link.serial_result_oe = oe_q;
  assign converting = conv_o_q;
  assign chain_mode = chain_q;
  assign busy_enabled = busy_q;
endmodule : asr_dev
`default_nettype wire

// ---- hw/asr_host.sv ----
// Host end: strobe, select and clock generation, result capture
`timescale 1ns/1ns
`default_nettype none
module asr_host #(
  parameter int N_DEV = 1,
  parameter int SCK_HALF = asr_pkg::SCK_HALF,
  parameter int CONV_WAIT = asr_pkg::CONV_CYC + asr_pkg::SYNC_MARGIN
) (
  input wire logic clk,
  input wire logic rst_b,
  asr_link_if.host link,
  input wire logic start,
  input wire logic use_chain,
  input wire logic use_busy,
  output logic [asr_pkg::RES_W*N_DEV-1:0] result,
  output logic done,
  output logic active
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_CONV, H_WAIT, H_CLK, H_END} asr_host_st_t;
  localparam int RXW = asr_pkg::RES_W * N_DEV + 1;
  localparam logic [15:0] HALF = 16'(SCK_HALF);
  localparam logic [15:0] CWAIT = 16'(CONV_WAIT);
  localparam logic [15:0] SETUP = 16'(asr_pkg::SETUP_CYC);

  logic [1:0] sdo_m_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sdo_m_q <= 2'h0;
    end else begin
      sdo_m_q <= {sdo_m_q[0], link.serial_result_level};
    end
  end
  wire sdo_s = sdo_m_q[1];

  asr_host_st_t st_q;
  logic chain_q, busy_q, cnv_q, sdi_q, sck_q, done_q;
  logic [15:0] tmr_q, bit_q;
  logic [RXW-1:0] rx_q;
  logic [asr_pkg::RES_W*N_DEV-1:0] res_q;
  wire tmr_zero = (tmr_q == 16'h0);
  wire [15:0] nbits = 16'(asr_pkg::RES_W * N_DEV) + {15'h0, busy_q};
  // Busy bit, when present, arrives first and is dropped
  wire busy_seen = chain_q ? sdo_s : ~sdo_s;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= H_IDLE;
      chain_q <= 1'b0;
      busy_q <= 1'b0;
      cnv_q <= 1'b0;
      sdi_q <= 1'b1;
      sck_q <= 1'b0;
      done_q <= 1'b0;
      tmr_q <= 16'h0;
      bit_q <= 16'h0;
      rx_q <= '0;
      res_q <= '0;
    end else begin
      done_q <= 1'b0;
      tmr_q <= tmr_zero ? 16'h0 : tmr_q - 16'h1;
      case (st_q)
        H_IDLE: begin
          cnv_q <= 1'b0;
          sdi_q <= 1'b1;
          sck_q <= 1'b0;
          if (start) begin
            chain_q <= use_chain;
            busy_q <= use_busy;
            sdi_q <= ~use_chain;
            sck_q <= use_chain & use_busy;
            tmr_q <= SETUP;
            st_q <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (tmr_zero) begin
            cnv_q <= 1'b1;
            tmr_q <= CWAIT;
            st_q <= H_CONV;
          end
        end
        H_CONV: begin
          // Select drops early when the busy bit is wanted
          if (!chain_q && busy_q && tmr_q == CWAIT - SETUP) begin
            sdi_q <= 1'b0;
          end
          if (chain_q && tmr_q == CWAIT - SETUP) begin
            sck_q <= 1'b0;
          end
          if (tmr_zero) begin
            if (!chain_q && !busy_q) begin
              sdi_q <= 1'b0;
            end
            tmr_q <= HALF + HALF;
            st_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (tmr_zero && (!busy_q || busy_seen)) begin
            bit_q <= 16'h0;
            tmr_q <= HALF;
            st_q <= H_CLK;
          end
        end
        H_CLK: begin
          if (tmr_zero) begin
            tmr_q <= HALF;
            if (!sck_q && bit_q == nbits) begin
              st_q <= H_END;
            end else if (!sck_q) begin
              sck_q <= 1'b1;
            end else begin
              // Sample late in the high phase, just before the fall
              rx_q <= {rx_q[RXW-2:0], sdo_s};
              sck_q <= 1'b0;
              bit_q <= bit_q + 16'h1;
            end
          end
        end
        H_END: begin
          cnv_q <= 1'b0;
          sdi_q <= 1'b1;
          res_q <= rx_q[RXW-2:0];
          done_q <= 1'b1;
          st_q <= H_IDLE;
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  logic act_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      act_q <= 1'b0;
    end else begin
      act_q <= (st_q != H_IDLE) && (st_q != H_END);
    end
  end

  assign link.convert_strobe = cnv_q;
  assign link.select_serial_in = sdi_q;
  assign link.sck = sck_q;
  assign result = res_q;
  assign done = done_q;
  assign active = act_q;
endmodule : asr_host
`default_nettype wire

// ---- inc/asr_link_if.sv ----
// Serial link between the converter end and the host end
`timescale 1ns/1ns
`default_nettype none
interface asr_link_if;
  logic convert_strobe;
  logic select_serial_in;
  logic sck;
  logic serial_result_out;
  logic serial_result_oe;
  logic serial_result_level;
  // Pull-up on the result line: undriven reads high
  assign serial_result_level = serial_result_oe ? serial_result_out : 1'b1;
  modport dev (
    input convert_strobe,
    input select_serial_in,
    input sck,
    output serial_result_out,
    output serial_result_oe
  );
  modport host (
    output convert_strobe,
    output select_serial_in,
    output sck,
    input serial_result_level
  );
endinterface : asr_link_if
`default_nettype wire

// ---- inc/asr_pkg.sv ----
// Shared constants for the serial result readout chain
package asr_pkg;
  localparam int RES_W = 18;
  localparam int CLK_MHZ = 250;
  localparam int T_CONV_NS = 500;
  localparam int CONV_CYC = (T_CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_MARGIN = 8;
  localparam int SETUP_CYC = 4;
  localparam int BITS_NOBUSY = 18;
  localparam int BITS_BUSY = 19;
  localparam int SCK_HALF = 8;
  localparam int SH_W = RES_W + 1;
  typedef enum logic {ASR_SEL = 1'b0, ASR_CHAIN = 1'b1} asr_mode_t;
endpackage : asr_pkg
